/* rsx_core.sv */
/*
 * Execution block for rotate-left/right through carry, power-down and
 * literal minus accumulator, with accumulator, status, a small file
 * register bank and a watchdog counter, all reached over AXI4-Lite.
 * Assumes one 50 MHz clock and a synchronous active-low reset.
 */
// Contract
// - Rotate left through carry, bit7 to carry
// - Rotate right through carry, bit0 to carry
// - Destination bit 0 accumulator, 1 file
// - Power-down clears power-down flag, sets time-out
// - Power-down clears watchdog counter and prescaler
// - Power-down enters sleep, single cycle
// - Recognise fixed power-down instruction pattern
// - Power-down: decode, idle, idle, sleep in Q4
// - Literal minus accumulator into accumulator
// - Decode top bits, ignore don't-care, literal low
// - Subtract updates carry, nibble, zero only
// - Subtract carry is inverted borrow
`timescale 1ns/1ps
`default_nettype none
module rsx_core import rsx_pkg::*; #(
   parameter int unsigned FILE_DEPTH   = FILE_DEPTH_DEF,
   parameter int unsigned PHASE_DIV    = PHASE_DIV_DEF,
   parameter int unsigned PRESCALE_DIV = PRESCALE_DIV_DEF
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic [2:0]        awprot,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic [2:0]        arprot,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [DATA_W-1:0]      rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic                   exec_busy,
   output logic                   sleep_active
);

   localparam int unsigned FA_W = (FILE_DEPTH > 1) ? $clog2(FILE_DEPTH) : 1;

   if (FILE_DEPTH < 2 || FILE_DEPTH > 128 ||
       (FILE_DEPTH & (FILE_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("FILE_DEPTH must be a power of two from 2 to 128");
   end
   if (PRESCALE_DIV < 1 || PRESCALE_DIV > 256) begin : g_bad_prescale
      $error("PRESCALE_DIV must be 1 to 256");
   end

   // ==========================================================
   // Bus handshake state
   // ==========================================================
   logic              aw_held, next_aw_held;
   logic [ADDR_W-1:0] aw_addr, next_aw_addr;
   logic              w_held, next_w_held;
   logic [DATA_W-1:0] w_data, next_w_data;
   logic [3:0]        w_strb, next_w_strb;
   logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0]        next_bresp, next_rresp;
   logic [DATA_W-1:0] next_rdata;
   logic              wr_fire;
   logic              wr_ok;
   logic [DATA_W-1:0] wr_mask;
   logic [7:0]        wr_off;

   // ==========================================================
   // Architectural and execution state
   // ==========================================================
   logic [INSTR_W-1:0] instr_q, next_instr_q;
   logic [7:0]         acc, next_acc;
   logic [7:0]         status, next_status;
   logic [FA_W-1:0]    fsel, next_fsel;
   logic [7:0]         file_mem [FILE_DEPTH];
   logic [7:0]         next_file_mem [FILE_DEPTH];
   rsx_op_type         op_q, next_op_q;
   logic [7:0]         fval_q, next_fval_q;
   logic [7:0]         res_q, next_res_q;
   logic [2:0]         flag_q, next_flag_q;
   logic               start_q, next_start_q;
   logic               next_exec_busy, next_sleep_active;
   logic               unknown_op, next_unknown_op;
   logic [7:0]         prescale, next_prescale;
   logic [7:0]         wdog, next_wdog;

   rsx_phase_type      phase;
   logic               step;
   rsx_op_type         alu_op;
   logic [7:0]         alu_res;
   logic               alu_c, alu_n, alu_z;
   logic [FA_W-1:0]    faddr;

   assign faddr = instr_q[FA_W-1:0];

   rsx_phase #(
      .PHASE_DIV (PHASE_DIV)
   ) u_phase (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (start_q),
      .phase   (phase),
      .step    (step)
   );

   rsx_alu u_alu (
      .instr      (instr_q),
      .acc        (acc),
      .fval       (fval_q),
      .carry_in   (status[ST_CARRY]),
      .op         (alu_op),
      .result     (alu_res),
      .carry_out  (alu_c),
      .nibble_out (alu_n),
      .zero_out   (alu_z)
   );

   function automatic logic mapped(input logic [7:0] a);
      return a == OFF_INSTR || a == OFF_ACC || a == OFF_STATUS || a == OFF_FSEL ||
             a == OFF_FDATA || a == OFF_STATE || a == OFF_WAKE || a == OFF_WDOG;
   endfunction : mapped

   // ==========================================================
   // AXI4-Lite slave handshake
   // ==========================================================
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rresp   = rresp;
      next_rdata   = rdata;
      wr_off       = {aw_addr[7:2], 2'b00};
      wr_fire      = aw_held && w_held && !bvalid;
      wr_ok        = mapped(wr_off) && !exec_busy &&
                     !(wr_off == OFF_INSTR && sleep_active);
      for (int i = 0; i < 4; i++)
         wr_mask[i*8 +: 8] = {8{w_strb[i]}};
      if (awvalid && awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_w_held = 1'b1;
         next_w_data = wdata;
         next_w_strb = wstrb;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         unique case ({araddr[7:2], 2'b00})
            OFF_INSTR:  next_rdata = DATA_W'(instr_q);
            OFF_ACC:    next_rdata = DATA_W'(acc);
            OFF_STATUS: next_rdata = DATA_W'(status);
            OFF_FSEL:   next_rdata = DATA_W'(fsel);
            OFF_FDATA:  next_rdata = DATA_W'(file_mem[fsel]);
            OFF_STATE:  next_rdata = DATA_W'({unknown_op, sleep_active, exec_busy});
            OFF_WAKE:   next_rdata = '0;
            OFF_WDOG:   next_rdata = DATA_W'({prescale, wdog});
            default: begin
               next_rdata = '0;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready  = !next_w_held && !next_bvalid;
      next_arready = !next_rvalid;
   end

   // ==========================================================
   // Registers, execution and watchdog
   // ==========================================================
   always_comb begin
      logic [DATA_W-1:0] merged;
      merged            = '0;
      next_instr_q      = instr_q;
      next_acc          = acc;
      next_status       = status;
      next_fsel         = fsel;
      next_file_mem     = file_mem;
      next_op_q         = op_q;
      next_fval_q       = fval_q;
      next_res_q        = res_q;
      next_flag_q       = flag_q;
      next_start_q      = 1'b0;
      next_exec_busy    = exec_busy;
      next_sleep_active = sleep_active;
      next_unknown_op   = unknown_op;
      next_prescale     = prescale;
      next_wdog         = wdog;

      // Free-running watchdog with prescaler
      if (prescale == 8'(PRESCALE_DIV - 1)) begin
         next_prescale = '0;
         next_wdog     = wdog + 8'h01;
      end else begin
         next_prescale = prescale + 8'h01;
      end

      if (wr_fire && wr_ok) begin
         unique case (wr_off)
            OFF_INSTR: begin
               merged         = (DATA_W'(instr_q) & ~wr_mask) | (w_data & wr_mask);
               next_instr_q   = merged[INSTR_W-1:0];
               next_start_q   = 1'b1;
               next_exec_busy = 1'b1;
            end
            OFF_ACC: begin
               merged   = (DATA_W'(acc) & ~wr_mask) | (w_data & wr_mask);
               next_acc = merged[7:0];
            end
            OFF_STATUS: begin
               merged      = (DATA_W'(status) & ~wr_mask) | (w_data & wr_mask);
               next_status = (status & ~STATUS_SW_MASK) | (merged[7:0] & STATUS_SW_MASK);
            end
            OFF_FSEL: begin
               merged    = (DATA_W'(fsel) & ~wr_mask) | (w_data & wr_mask);
               next_fsel = merged[FA_W-1:0];
            end
            OFF_FDATA: begin
               merged              = (DATA_W'(file_mem[fsel]) & ~wr_mask) |
                                     (w_data & wr_mask);
               next_file_mem[fsel] = merged[7:0];
            end
            OFF_STATE: begin
               if (w_strb[0] && w_data[SR_UNKNOWN])
                  next_unknown_op = 1'b0;
            end
            OFF_WAKE: begin
               if (w_strb[0] && w_data[0])
                  next_sleep_active = 1'b0;
            end
            default: begin
            end
         endcase
      end

      // Phase-by-phase execution; hardware events win over clears
      if (step) begin
         unique case (phase)
            PH_Q1: next_op_q = alu_op;
            PH_Q2: next_fval_q = file_mem[faddr];
            PH_Q3: begin
               next_res_q  = alu_res;
               next_flag_q = {alu_z, alu_n, alu_c};
            end
            PH_Q4: begin
               next_exec_busy = 1'b0;
               unique case (op_q)
                  OP_ROT_LEFT, OP_ROT_RIGHT: begin
                     if (instr_q[DEST_BIT])
                        next_file_mem[faddr] = res_q;
                     else
                        next_acc = res_q;
                     next_status[ST_CARRY] = flag_q[0];
                  end
                  OP_LIT_MINUS: begin
                     next_acc               = res_q;
                     next_status[ST_CARRY]  = flag_q[0];
                     next_status[ST_NIBBLE] = flag_q[1];
                     next_status[ST_ZERO]   = flag_q[2];
                  end
                  OP_POWER_DOWN: begin
                     next_status[ST_POWER_DOWN] = 1'b0;
                     next_status[ST_TIME_OUT]   = 1'b1;
                     next_wdog                  = '0;
                     next_prescale              = '0;
                     next_sleep_active          = 1'b1;
                  end
                  default: next_unknown_op = 1'b1;
               endcase
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         aw_addr      <= '0;
         w_held       <= 1'b0;
         w_data       <= '0;
         w_strb       <= '0;
         awready      <= 1'b0;
         wready       <= 1'b0;
         bvalid       <= 1'b0;
         bresp        <= RESP_OKAY;
         arready      <= 1'b0;
         rvalid       <= 1'b0;
         rresp        <= RESP_OKAY;
         rdata        <= '0;
         instr_q      <= '0;
         acc          <= '0;
         status       <= STATUS_RESET;
         fsel         <= '0;
         for (int i = 0; i < FILE_DEPTH; i++)
            file_mem[i] <= '0;
         op_q         <= OP_NONE;
         fval_q       <= '0;
         res_q        <= '0;
         flag_q       <= '0;
         start_q      <= 1'b0;
         exec_busy    <= 1'b0;
         sleep_active <= 1'b0;
         unknown_op   <= 1'b0;
         prescale     <= '0;
         wdog         <= '0;
      end else begin
         aw_held      <= next_aw_held;
         aw_addr      <= next_aw_addr;
         w_held       <= next_w_held;
         w_data       <= next_w_data;
         w_strb       <= next_w_strb;
         awready      <= next_awready;
         wready       <= next_wready;
         bvalid       <= next_bvalid;
         bresp        <= next_bresp;
         arready      <= next_arready;
         rvalid       <= next_rvalid;
         rresp        <= next_rresp;
         rdata        <= next_rdata;
         instr_q      <= next_instr_q;
         acc          <= next_acc;
         status       <= next_status;
         fsel         <= next_fsel;
         file_mem     <= next_file_mem;
         op_q         <= next_op_q;
         fval_q       <= next_fval_q;
         res_q        <= next_res_q;
         flag_q       <= next_flag_q;
         start_q      <= next_start_q;
         exec_busy    <= next_exec_busy;
         sleep_active <= next_sleep_active;
         unknown_op   <= next_unknown_op;
         prescale     <= next_prescale;
         wdog         <= next_wdog;
      end
   end

endmodule : rsx_core
`default_nettype wire

/* rsx_pkg.sv */
/*
 * Shared constants for the rotate / power-down / literal-subtract
 * execution block: register map, status layout, opcode patterns, types.
 * Assumes a single 50 MHz clock and a 32-bit AXI4-Lite register bus.
 */
package rsx_pkg;

   // ==========================================================
   // Bus and register map
   // ==========================================================
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned ADDR_W      = 8;
   localparam logic [7:0]  OFF_INSTR   = 8'h00;
   localparam logic [7:0]  OFF_ACC     = 8'h04;
   localparam logic [7:0]  OFF_STATUS  = 8'h08;
   localparam logic [7:0]  OFF_FSEL    = 8'h0C;
   localparam logic [7:0]  OFF_FDATA   = 8'h10;
   localparam logic [7:0]  OFF_STATE   = 8'h14;
   localparam logic [7:0]  OFF_WAKE    = 8'h18;
   localparam logic [7:0]  OFF_WDOG    = 8'h1C;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ==========================================================
   // Status register fields
   // ==========================================================
   localparam int unsigned ST_CARRY      = 0;
   localparam int unsigned ST_NIBBLE     = 1;
   localparam int unsigned ST_ZERO       = 2;
   localparam int unsigned ST_POWER_DOWN = 3;
   localparam int unsigned ST_TIME_OUT   = 4;
   localparam logic [7:0]  STATUS_RESET  = 8'h18;
   localparam logic [7:0]  STATUS_SW_MASK = 8'h07;

   // State register fields
   localparam int unsigned SR_BUSY    = 0;
   localparam int unsigned SR_SLEEP   = 1;
   localparam int unsigned SR_UNKNOWN = 2;

   // ==========================================================
   // Opcode patterns
   // ==========================================================
   localparam int unsigned INSTR_W     = 14;
   localparam logic [5:0]  ROTL_TOP    = 6'h0D;
   localparam logic [5:0]  ROTR_TOP    = 6'h0C;
   localparam logic [13:0] SLEEP_WORD  = 14'h0063;
   localparam logic [4:0]  LITSUB_TOP  = 5'h1E;
   localparam int unsigned DEST_BIT    = 7;
   localparam int unsigned FADDR_W     = 7;

   // ==========================================================
   // Timing and size defaults
   // ==========================================================
   localparam int unsigned PHASE_DIV_DEF    = 1;
   localparam int unsigned PRESCALE_DIV_DEF = 16;
   localparam int unsigned FILE_DEPTH_DEF   = 16;

   typedef enum logic [2:0] {
      PH_IDLE = 3'h0,
      PH_Q1   = 3'h1,
      PH_Q2   = 3'h3,
      PH_Q3   = 3'h2,
      PH_Q4   = 3'h6
   } rsx_phase_type;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_ROT_LEFT,
      OP_ROT_RIGHT,
      OP_POWER_DOWN,
      OP_LIT_MINUS
   } rsx_op_type;

endpackage : rsx_pkg

/* rsx_alu.sv */
/*
 * Instruction decode and data path for rotate through carry and
 * literal minus accumulator. Purely combinational.
 * Assumes the caller latches inputs and results at the phase edges.
 */
`timescale 1ns/1ps
`default_nettype none
module rsx_alu import rsx_pkg::*; (
   input  wire logic [INSTR_W-1:0] instr,
   input  wire logic [7:0]         acc,
   input  wire logic [7:0]         fval,
   input  wire logic               carry_in,
   output var  rsx_op_type         op,
   output logic [7:0]              result,
   output logic                    carry_out,
   output logic                    nibble_out,
   output logic                    zero_out
);

   logic [8:0] diff;
   logic [4:0] nib;

   // Borrow seen as bit 8 / bit 4 of zero-extended differences
   assign diff = {1'b0, instr[7:0]} - {1'b0, acc};
   assign nib  = {1'b0, instr[3:0]} - {1'b0, acc[3:0]};

   always_comb begin
      op         = OP_NONE;
      result     = fval;
      carry_out  = carry_in;
      nibble_out = 1'b0;
      zero_out   = 1'b0;
      if (instr[13:8] == ROTL_TOP) begin
         op        = OP_ROT_LEFT;
         result    = {fval[6:0], carry_in};
         carry_out = fval[7];
      end else if (instr[13:8] == ROTR_TOP) begin
         op        = OP_ROT_RIGHT;
         result    = {carry_in, fval[7:1]};
         carry_out = fval[0];
      end else if (instr == SLEEP_WORD) begin
         op = OP_POWER_DOWN;
      end else if (instr[13:9] == LITSUB_TOP) begin
         op         = OP_LIT_MINUS;
         result     = diff[7:0];
         carry_out  = ~diff[8];
         nibble_out = ~nib[4];
         zero_out   = (diff[7:0] == 8'h00);
      end
   end

endmodule : rsx_alu
`default_nettype wire

/* rsx_phase.sv */
/*
 * Four-phase instruction cycle sequencer. Each phase lasts PHASE_DIV
 * clocks; step pulses on the last clock of each phase.
 * Assumes start is a one-cycle pulse raised only while idle.
 */
`timescale 1ns/1ps
`default_nettype none
module rsx_phase import rsx_pkg::*; #(
   parameter int unsigned PHASE_DIV = PHASE_DIV_DEF
) (
   input  wire logic   aclk,
   input  wire logic   aresetn,
   input  wire logic   start,
   output var  rsx_phase_type phase,
   output logic        step
);

   localparam int unsigned CNT_W = (PHASE_DIV > 1) ? $clog2(PHASE_DIV) : 1;

   if (PHASE_DIV < 1 || PHASE_DIV > 256) begin : g_bad_div
      $error("PHASE_DIV must be 1 to 256");
   end

   rsx_phase_type          next_phase;
   logic [CNT_W-1:0]       div_cnt;
   logic [CNT_W-1:0]       next_div_cnt;

   assign step = (phase != PH_IDLE) && (div_cnt == CNT_W'(PHASE_DIV - 1));

   always_comb begin
      next_phase   = phase;
      next_div_cnt = div_cnt;
      unique case (phase)
         PH_IDLE: begin
            next_div_cnt = '0;
            if (start)
               next_phase = PH_Q1;
         end
         PH_Q1, PH_Q2, PH_Q3, PH_Q4: begin
            if (step) begin
               next_div_cnt = '0;
               unique case (phase)
                  PH_Q1:   next_phase = PH_Q2;
                  PH_Q2:   next_phase = PH_Q3;
                  PH_Q3:   next_phase = PH_Q4;
                  default: next_phase = PH_IDLE;
               endcase
            end else begin
               next_div_cnt = div_cnt + CNT_W'(1);
            end
         end
         default: begin
            next_phase   = PH_IDLE;
            next_div_cnt = '0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase   <= PH_IDLE;
         div_cnt <= '0;
      end else begin
         phase   <= next_phase;
         div_cnt <= next_div_cnt;
      end
   end

endmodule : rsx_phase
`default_nettype wire

/* rsx_core_monitor.sv */
/* Port checker for rsx_core: bus handshakes and execution timing.
   Assumes one clock and a synchronous active-low reset; bound below. */
`timescale 1ns/1ps
`default_nettype none
module rsx_core_monitor (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        awvalid,
   input wire logic        awready,
   input wire logic        wvalid,
   input wire logic        wready,
   input wire logic [1:0]  bresp,
   input wire logic        bvalid,
   input wire logic        bready,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   input wire logic        rready,
   input wire logic        exec_busy,
   input wire logic        sleep_active
);
   // ==========================================================
   // Handshakes and execution timing
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_WR_ANSWER: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
      else $error("write not answered");
   AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid)
      else $error("read not answered");
   AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   AST_BUSY_START: assert property ($rose(exec_busy) |-> $rose(bvalid))
      else $error("busy without accepted write");
   AST_BUSY_LEN: assert property ($rose(exec_busy) |-> exec_busy [*4] ##[1:9] !exec_busy)
      else $error("busy length wrong");
   AST_SLEEP_AT_END: assert property ($rose(sleep_active) |-> $fell(exec_busy))
      else $error("sleep not entered at cycle end");
   AST_WAKE_BY_WRITE: assert property ($fell(sleep_active) |-> $rose(bvalid))
      else $error("sleep left without wake write");
endmodule : rsx_core_monitor
bind rsx_core rsx_core_monitor i_mon (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
   .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .exec_busy,
   .sleep_active);
`default_nettype wire

/* testbench.sv */
/* Self-checking bench for rsx_core over AXI4-Lite.
   Assumes rsx_pkg, the design and its bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench import rsx_pkg::*;;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, seed = 32'hc6aa_78e8;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, exec_busy, sleep_active;
   logic [1:0]  bresp, rresp, bq[$];
   logic [65:0] rq[$];
   int          err_total = 0, checks = 0;

   always #10 aclk = ~aclk;

   rsx_core #(.PHASE_DIV(2)) i_dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
      .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
      .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .exec_busy,
      .sleep_active);

   // ==========================================================
   // Stimulus helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      bit aw = 0, w = 0;
      bq.push_back(r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (awready) begin
            aw = 1;
            awvalid <= 1'b0;
         end
         if (wready) begin
            w = 1;
            wvalid <= 1'b0;
         end
      end
      while (!bvalid) @(posedge aclk);
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY,
                     input logic [31:0] m = 32'hffff_ffff);
      rq.push_back({m, r, d & m});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
   endtask : rd

   task automatic print_verdict();
      if (err_total == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict

   // Result watcher: oldest note against each response
   always @(posedge aclk) begin
      logic [65:0] e;
      logic [1:0]  b;
      if (rvalid && rready) begin
         e = rq.pop_front();
         checks++;
         if ({rresp, rdata & e[65:34]} !== e[33:0]) begin
            $display("unexpected read: expected %h seen %h", e[33:0], {rresp, rdata});
            err_total++;
         end
      end
      if (bvalid && bready) begin
         b = bq.pop_front();
         checks++;
         if (bresp !== b) begin
            $display("unexpected bresp: expected %h seen %h", b, bresp);
            err_total++;
         end
      end
   end

   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      print_verdict();
   end

   // ==========================================================
   // Main sequence
   initial begin
      logic [31:0] v;
      logic [7:0]  acc, fv, k, r, st;
      logic [6:0]  f;
      logic [13:0] ins;
      logic        c, dd;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         v = rnd();
         acc = (i < 8) ? v[7:0] : 8'(i - 7);
         k = (i < 8) ? v[31:24] : 8'h02;
         fv = v[15:8];
         f = v[22:16];
         c = v[23];
         dd = i[2];
         wr(OFF_ACC, {24'h0, acc});
         wr(OFF_STATUS, {31'h0, c});
         wr(OFF_FSEL, {28'h0, f[3:0]});
         wr(OFF_FDATA, {24'h0, fv});
         if (i < 8 && i % 4 < 2) begin
            ins = {i[0] ? ROTR_TOP : ROTL_TOP, dd, f};
            r = i[0] ? {c, fv[7:1]} : {fv[6:0], c};
            st = {7'h0c, i[0] ? fv[0] : fv[7]};
         end else begin
            ins = {LITSUB_TOP, i[0], k};
            r = k - acc;
            st = {5'h03, r == 8'h0, k[3:0] >= acc[3:0], k >= acc};
            dd = 1'b0;
         end
         wr(OFF_INSTR, {18'h0, ins});
         while (exec_busy) @(posedge aclk);
         rd(OFF_ACC, {24'h0, dd ? acc : r});
         rd(OFF_FDATA, {24'h0, dd ? r : fv});
         rd(OFF_STATUS, {24'h0, st});
      end
      wr(OFF_INSTR, {18'h0, SLEEP_WORD});
      while (exec_busy) @(posedge aclk);
      rd(OFF_STATUS, {24'h0, st & 8'h07 | 8'h10});
      rd(OFF_WDOG, 32'h0000_0500);
      rd(OFF_STATE, 32'h2);
      wr(OFF_INSTR, 32'h0000_0d00, RESP_SLVERR);
      wr(OFF_WAKE, 32'h1);
      wr(OFF_INSTR, 32'h0000_3c05);
      wr(OFF_ACC, 32'h0, RESP_SLVERR);
      while (exec_busy) @(posedge aclk);
      rd(OFF_ACC, {24'h0, 8'h05 - r});
      wr(OFF_INSTR, 32'h0000_0000);
      while (exec_busy) @(posedge aclk);
      rd(OFF_STATE, 32'h4);
      wr(OFF_STATE, 32'h4);
      rd(OFF_STATE, 32'h0);
      rd(OFF_ACC, {24'h0, 8'h05 - r});
      rd(8'h20, 32'h0, RESP_SLVERR);
      @(posedge aclk);
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
